// file: hw/csf_pkg.sv
/*
 csf_pkg: shared constants and types of the charger status and flag bank.
 Assumes a single 100 MHz clock domain; condition inputs come from analog
 comparators and state machines outside this clock domain.
*/
package csf_pkg;

	// register offsets on the control port
	localparam logic [7:0] OFS_TEMP   = 8'h1f;
	localparam logic [7:0] OFS_FAULTA = 8'h20;
	localparam logic [7:0] OFS_FAULTB = 8'h21;
	localparam logic [7:0] OFS_FLAGA  = 8'h22;
	localparam logic [7:0] OFS_FLAGB  = 8'h23;

	// value of the flag registers, pointer and shift register after reset; status registers follow live inputs
	localparam logic [7:0] REG_RESET = 8'h00;

	// 7-bit target address on the control port; value is arbitrary
	localparam logic [6:0] DEV_ADDR_DEF = 7'h35;

	// last bit index within a serial byte
	localparam logic [2:0] LAST_BIT = 3'h7;

	// stages of the input synchroniser
	localparam int SYNC_STAGES = 2;

	// live conditions that feed the status and flag registers
	typedef struct packed {
		logic       otgBattLow;    // battery too low for otg
		logic       belowT1;       // thermistor below cold threshold
		logic       belowT2;       // thermistor below cool threshold
		logic       belowT3;       // thermistor below warm threshold
		logic       belowT5;       // thermistor below hot threshold
		logic       dischgReg;     // discharge current regulation
		logic       busOv;         // input bus overvoltage
		logic       battOv;        // battery overvoltage
		logic       busOc;         // input bus overcurrent
		logic       battOc;        // battery overcurrent
		logic       convOc;        // converter overcurrent
		logic       adBOv;         // second adapter overvoltage
		logic       adAOv;         // first adapter overvoltage
		logic       sysShort;      // system rail short
		logic       sysOv;         // system rail overvoltage
		logic       otgOv;         // otg output overvoltage
		logic       otgUv;         // otg output undervoltage
		logic       thermShut;     // thermal shutdown
		logic       inCurReg;      // input or otg current regulation
		logic       inVoltReg;     // input or otg voltage regulation
		logic       wdExpired;     // host watchdog expired
		logic       weakAdapter;   // weak adapter detected
		logic       powerGood;     // power good
		logic       adBPresent;    // second adapter present
		logic       adAPresent;    // first adapter present
		logic       busPresent;    // input bus present
		logic [2:0] chargeState;   // charge state code
		logic [1:0] icoState;      // current optimizer state
		logic [3:0] busType;       // input bus type code
		logic       dieThermReg;   // die thermal regulation
		logic       battPresent;   // battery present
		logic       portDetDone;   // port detection complete
	} csf_cond_s;

	// control port target states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_PTR,
		ST_PTR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} csf_state_e;

endpackage

// file: hw/csf_sync.sv
/*
 csf_sync: multi-bit two-stage synchroniser with clock enable.
 Assumes each bit is an independent level; no word coherence is promised.
*/
`timescale 1ns/1ns
`default_nettype none

module csf_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,      // system clock
	input  wire logic         reset_n,  // async reset, active low
	input  wire logic         ce,       // clock enable
	input  wire logic [W-1:0] d,        // asynchronous inputs
	output var  logic [W-1:0] q         // synchronised outputs
);
	import csf_pkg::*;

	logic [W-1:0] stage1;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= '0;
			q      <= '0;
		end else if (ce) begin
			stage1 <= d;
			q      <= stage1;
		end
	end

endmodule

`default_nettype wire

// file: hw/csf_status_flag_bank.sv
/*
 csf_status_flag_bank: read-only status and event-flag registers of a
 charger, read by a host over a two-wire serial control port.
 Assumes scl/sda and all condition inputs are asynchronous levels, and the
 sda wire is resolved outside (open drain, low while sdaOe is high).
*/
`timescale 1ns/1ns
`default_nettype none

module csf_status_flag_bank #(
	parameter logic [6:0] DEV_ADDR = csf_pkg::DEV_ADDR_DEF
) (
	input  wire logic              clk,      // 100 mhz system clock
	input  wire logic              reset_n,  // async reset, active low
	input  wire logic              ce,       // clock enable, freezes all
	input  wire logic              sclIn,    // serial clock pin
	input  wire logic              sdaIn,    // serial data pin level
	output var  logic              sdaOut,   // serial data drive value
	output var  logic              sdaOe,    // pulls sda low when high
	input  wire logic [15:0]       irqMask,  // [15:8] flag a, [7:0] flag b
	input  wire csf_pkg::csf_cond_s cond,    // live charger conditions
	output var  logic              intPulse  // one-cycle event pulse
);
	import csf_pkg::*;

	localparam int CW = $bits(csf_cond_s);

	logic [CW+1:0] rawIn;
	logic [CW+1:0] syncOut;
	logic          sclS;
	logic          sdaS;
	csf_cond_s     c;
	logic          sclD;
	logic          sdaD;
	csf_cond_s     cPrev;
	logic          start;
	logic          stop;
	logic          sclRise;
	logic          sclFall;
	logic [7:0]    tempReg;
	logic [7:0]    faultA;
	logic [7:0]    faultB;
	logic [7:0]    flagA;
	logic [7:0]    flagB;
	logic [7:0]    setA;
	logic [7:0]    setB;
	logic [7:0]    clrA;
	logic [7:0]    clrB;
	logic [7:0]    next_flagA;
	logic [7:0]    next_flagB;
	csf_state_e    state;
	logic [2:0]    bitCnt;
	logic          gotByte;
	logic [7:0]    shiftReg;
	logic [7:0]    ptr;
	logic          rwRead;
	logic          masterAck;
	logic          loadRd;
	logic [7:0]    rdAddr;
	logic [7:0]    rdData;

	// rising edge of a synchronised level
	function automatic logic risen(input logic now, input logic was);
		return now & ~was;
	endfunction

	// all cross through two flops; bus pins inverted so reset reads idle
	assign rawIn = {~sclIn, ~sdaIn, cond};

	csf_sync #(
		.W(CW + 2)
	) uSync (
		.clk     (clk),
		.reset_n (reset_n),
		.ce      (ce),
		.d       (rawIn),
		.q       (syncOut)
	);

	assign {sclS, sdaS, c} = syncOut ^ {2'b11, {CW{1'b0}}};

	// delayed copies for edge and change detection
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sclD  <= 1'b1;
			sdaD  <= 1'b1;
			cPrev <= '0;
		end else if (ce) begin
			sclD  <= sclS;
			sdaD  <= sdaS;
			cPrev <= c;
		end
	end

	// bus conditions seen on the synchronised wire
	assign start   = sclS & sclD & sdaD & ~sdaS;
	assign stop    = sclS & sclD & ~sdaD & sdaS;
	assign sclRise = sclS & ~sclD;
	assign sclFall = ~sclS & sclD;

	// thermistor ranges from ordered threshold comparators
	assign tempReg[7:5] = 3'h0;
	assign tempReg[4]   = c.otgBattLow;
	assign tempReg[3]   = c.belowT1;
	assign tempReg[2]   = c.belowT2 & ~c.belowT1;
	assign tempReg[1]   = ~c.belowT3 & c.belowT5;
	assign tempReg[0]   = ~c.belowT5;

	// first fault register follows live protection states
	assign faultA[7] = c.dischgReg;
	assign faultA[6] = c.busOv;
	assign faultA[5] = c.battOv;
	assign faultA[4] = c.busOc;
	assign faultA[3] = c.battOc;
	assign faultA[2] = c.convOc;
	assign faultA[1] = c.adBOv;
	assign faultA[0] = c.adAOv;

	// second fault register, reserved bits tied low
	assign faultB[7]   = c.sysShort;
	assign faultB[6]   = c.sysOv;
	assign faultB[5]   = c.otgOv;
	assign faultB[4]   = c.otgUv;
	assign faultB[3]   = 1'b0;
	assign faultB[2]   = c.thermShut;
	assign faultB[1:0] = 2'h0;

	// first flag register events
	assign setA[7] = risen(c.inCurReg, cPrev.inCurReg);
	assign setA[6] = risen(c.inVoltReg, cPrev.inVoltReg);
	assign setA[5] = risen(c.wdExpired, cPrev.wdExpired);
	assign setA[4] = risen(c.weakAdapter, cPrev.weakAdapter);
	assign setA[3] = c.powerGood ^ cPrev.powerGood;
	assign setA[2] = c.adBPresent ^ cPrev.adBPresent;
	assign setA[1] = c.adAPresent ^ cPrev.adAPresent;
	assign setA[0] = c.busPresent ^ cPrev.busPresent;

	// second flag register events; bits 5 and 3 stay reserved
	assign setB[7] = c.chargeState != cPrev.chargeState;
	assign setB[6] = c.icoState != cPrev.icoState;
	assign setB[5] = 1'b0;
	assign setB[4] = c.busType != cPrev.busType;
	assign setB[3] = 1'b0;
	assign setB[2] = risen(c.dieThermReg, cPrev.dieThermReg);
	assign setB[1] = c.battPresent ^ cPrev.battPresent;
	assign setB[0] = c.portDetDone ^ cPrev.portDetDone;

	// a read clears the whole flag register it fetched
	assign clrA = (loadRd && rdAddr == OFS_FLAGA) ? 8'hff : 8'h00;
	assign clrB = (loadRd && rdAddr == OFS_FLAGB) ? 8'hff : 8'h00;

	// set wins over the read clear so no event is lost
	assign next_flagA = (flagA & ~clrA) | setA;
	assign next_flagB = (flagB & ~clrB) | setB;

	// sticky flags
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			flagA <= REG_RESET;
			flagB <= REG_RESET;
		end else if (ce) begin
			flagA <= next_flagA;
			flagB <= next_flagB;
		end
	end

	// interrupt pulse in each cycle that has at least one unmasked new event
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			intPulse <= 1'b0;
		end else if (ce) begin
			intPulse <= |((setA & ~irqMask[15:8]) | (setB & ~irqMask[7:0]));
		end
	end

	// byte fetch: on address ack of a read, or on master ack
	assign loadRd = ce & ~start & ~stop & sclFall &
		((state == ST_ADDR_ACK & rwRead) | (state == ST_RD_ACK & masterAck));
	assign rdAddr = (state == ST_RD_ACK) ? ptr + 8'h01 : ptr;

	// read decode; unmapped offsets read zero
	always_comb begin
		if (rdAddr == OFS_TEMP) begin
			rdData = tempReg;
		end else if (rdAddr == OFS_FAULTA) begin
			rdData = faultA;
		end else if (rdAddr == OFS_FAULTB) begin
			rdData = faultB;
		end else if (rdAddr == OFS_FLAGA) begin
			rdData = flagA;
		end else if (rdAddr == OFS_FLAGB) begin
			rdData = flagB;
		end else begin
			rdData = REG_RESET;
		end
	end

	// open drain: the driven level is always low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sdaOut <= 1'b0;
		end else if (ce) begin
			sdaOut <= 1'b0;
		end
	end

	// serial target; writes only move the pointer, data bytes are
	// acknowledged and dropped since every register here is read-only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state     <= ST_IDLE;
			bitCnt    <= 3'h0;
			gotByte   <= 1'b0;
			shiftReg  <= REG_RESET;
			ptr       <= REG_RESET;
			rwRead    <= 1'b0;
			masterAck <= 1'b0;
			sdaOe     <= 1'b0;
		end else if (ce) begin
			if (start) begin
				state   <= ST_ADDR;
				bitCnt  <= 3'h0;
				gotByte <= 1'b0;
				sdaOe   <= 1'b0;
			end else if (stop) begin
				state <= ST_IDLE;
				sdaOe <= 1'b0;
			end else if (loadRd) begin
				shiftReg <= rdData;
				ptr      <= rdAddr;
				sdaOe    <= ~rdData[7];
				bitCnt   <= 3'h0;
				state    <= ST_RD;
			end else begin
				case (state)
					ST_ADDR, ST_PTR, ST_WR: begin
						if (sclRise) begin
							shiftReg <= {shiftReg[6:0], sdaS};
							bitCnt   <= bitCnt + 3'h1;
							gotByte  <= (bitCnt == LAST_BIT);
						end else if (sclFall && gotByte) begin
							gotByte <= 1'b0;
							if (state == ST_ADDR) begin
								if (shiftReg[7:1] == DEV_ADDR) begin
									rwRead <= shiftReg[0];
									sdaOe  <= 1'b1;
									state  <= ST_ADDR_ACK;
								end else begin
									state <= ST_IDLE;
								end
							end else if (state == ST_PTR) begin
								ptr   <= shiftReg;
								sdaOe <= 1'b1;
								state <= ST_PTR_ACK;
							end else begin
								sdaOe <= 1'b1;
								state <= ST_WR_ACK;
							end
						end
					end
					ST_ADDR_ACK: begin
						// read case is taken by the fetch above
						if (sclFall) begin
							sdaOe <= 1'b0;
							state <= ST_PTR;
						end
					end
					ST_PTR_ACK, ST_WR_ACK: begin
						if (sclFall) begin
							sdaOe <= 1'b0;
							state <= ST_WR;
						end
					end
					ST_RD: begin
						if (sclFall) begin
							if (bitCnt == LAST_BIT) begin
								sdaOe <= 1'b0;
								state <= ST_RD_ACK;
							end else begin
								shiftReg <= {shiftReg[6:0], 1'b0};
								sdaOe    <= ~shiftReg[6];
								bitCnt   <= bitCnt + 3'h1;
							end
						end
					end
					ST_RD_ACK: begin
						// a nack ends the read; wait for stop or start
						if (sclRise) begin
							masterAck <= ~sdaS;
						end else if (sclFall) begin
							state <= ST_IDLE;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
		end
	end

	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!reset_n);

	// two enabled cycles carry a pin level into the status view
	sequence twoEnabled;
		$past(ce) && $past(ce, 2) && $past(reset_n) && $past(reset_n, 2);
	endsequence

	sequence pgToggle;
		ce && (c.powerGood != cPrev.powerGood);
	endsequence

	a_otg_low_track: assert property (twoEnabled |-> tempReg[4] == $past(cond.otgBattLow, 2))
		else $error("otg battery low status does not follow input");

	a_cold_track: assert property (twoEnabled |-> tempReg[3] == $past(cond.belowT1, 2))
		else $error("cold status does not follow input");

	a_hot_track: assert property (twoEnabled |-> tempReg[0] == !$past(cond.belowT5, 2))
		else $error("hot status does not follow input");

	a_bus_ovp_track: assert property (twoEnabled |-> faultA[6] == $past(cond.busOv, 2))
		else $error("bus overvoltage status does not follow input");

	a_fault_rsvd_zero: assert property (loadRd && rdAddr == OFS_FAULTB
		|-> rdData[3] == 1'b0 && rdData[1:0] == 2'h0)
		else $error("reserved fault bits read nonzero");

	a_cur_reg_flag: assert property (ce && c.inCurReg && !cPrev.inCurReg |=> flagA[7])
		else $error("current regulation rise not flagged");

	a_pg_change_flag: assert property (pgToggle |=> flagA[3])
		else $error("power good change not flagged");

	a_charge_flag: assert property (ce && c.chargeState != cPrev.chargeState |=> flagB[7])
		else $error("charge state change not flagged");

	a_flag_read_clear: assert property (ce && loadRd && rdAddr == OFS_FLAGA
		|=> flagA == $past(setA))
		else $error("flag read did not clear to new events");

	a_flag_hold: assert property (ce && flagB[1] && !clrB[1] |=> flagB[1])
		else $error("flag dropped without a read");

	a_irq_pulse: assert property (ce && ((setA & ~irqMask[15:8]) != 8'h00)
		|=> intPulse)
		else $error("unmasked event gave no interrupt pulse");

	a_irq_quiet: assert property (ce && ((setA & ~irqMask[15:8]) == 8'h00)
		&& ((setB & ~irqMask[7:0]) == 8'h00) |=> !intPulse)
		else $error("interrupt pulse without unmasked event");

endmodule

`default_nettype wire

// file: test/csf_host_model.sv
/*
 csf_host_model: serial control port host that reads the status bank.
 Assumes the bench resolves the open-drain sda wire with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none

module csf_host_model #(
	parameter logic [6:0] ADDR = 7'h35,  // target address
	parameter int         HALF = 6       // clk cycles per scl phase
) (
	input  wire logic clk,      // system clock
	input  wire logic sdaWire,  // resolved sda level
	output var  logic scl,      // serial clock, idles high
	output var  logic sdaLow    // pulls sda low when high
);
	logic [7:0] rd [0:4];  // bytes of the last read
	int         ackMiss;   // acks that never came

	// bus idle: both lines released
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
		ackMiss = 0;
	end

	// one scl phase, well above the three-cycle minimum
	task automatic hold();
		repeat (HALF) @(negedge clk);
	endtask

	// sda moves mid-low only, so no edge is mistaken for start or stop
	task automatic put_bit(input logic b, output logic got);
		sdaLow = !b;
		hold();
		scl = 1'b1;
		hold();
		got = sdaWire;
		scl = 1'b0;
		hold();
	endtask

	// start, also used as repeated start
	task automatic start();
		sdaLow = 1'b0;
		hold();
		scl = 1'b1;
		hold();
		sdaLow = 1'b1;
		hold();
		scl = 1'b0;
		hold();
	endtask

	task automatic stop();
		sdaLow = 1'b1;
		hold();
		scl = 1'b1;
		hold();
		sdaLow = 1'b0;
		hold();
	endtask

	// eight bits msb first, then the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ackBit, output logic [7:0] rx,
			output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			put_bit(tx[i], g);
			rx[i] = g;
		end
		put_bit(ackBit, g);
		ack = !g;
	endtask

	task automatic send(input logic [7:0] b);
		logic [7:0] rx;
		logic       a;
		xfer(b, 1'b1, rx, a);
		if (a !== 1'b1) ackMiss++;
	endtask

	// address-only call, reports whether a target answered
	task automatic probe(input logic [6:0] a, output logic ack);
		logic [7:0] rx;
		start();
		xfer({a, 1'b0}, 1'b1, rx, ack);
		stop();
	endtask

	task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
		start();
		send({ADDR, 1'b0});
		send(ptr);
		send(d);
		stop();
	endtask

	// read n bytes from ptr, last one not acknowledged
	task automatic read_regs(input logic [7:0] ptr, input int n);
		logic a;
		start();
		send({ADDR, 1'b0});
		send(ptr);
		start();
		send({ADDR, 1'b1});
		for (int k = 0; k < n; k++) xfer(8'hff, k == n - 1, rd[k], a);
		stop();
	endtask
endmodule

`default_nettype wire

// file: test/test_csf_status_flag_bank.sv
/*
 test_csf_status_flag_bank: self-checking bench of the status and flag bank.
 Assumes the host model on the control port and a pulled-up sda wire.
*/
`timescale 1ns/1ns
`default_nettype none

module test_csf_status_flag_bank;
	import csf_pkg::*;

	logic        clk;      // system clock
	logic        reset_n;  // reset, active low
	logic        ce;       // clock enable
	logic        sclPin;   // serial clock from host
	logic        hostLow;  // host pulls sda
	logic        sdaOut;   // device drive value
	logic        sdaOe;    // device pulls sda
	logic        sdaWire;  // resolved sda
	logic [15:0] irqMask;  // event masks
	csf_cond_s   cond;     // live conditions
	logic        intPulse; // event pulse
	int          errorCnt = 0;
	int          samplesChecked = 0;
	int          pulseCnt = 0;
	int          cycles = 0;

	// open drain with pull-up
	assign sdaWire = (sdaOe ? sdaOut : 1'b1) & !hostLow;

	csf_status_flag_bank i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .sclIn(sclPin),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .irqMask(irqMask), .cond(cond),
		.intPulse(intPulse));

	csf_host_model #(.ADDR(DEV_ADDR_DEF)) i_host (.clk(clk), .sdaWire(sdaWire), .scl(sclPin),
		.sdaLow(hostLow));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// pulse count and hang guard; ceiling well above the run length
	always @(posedge clk) begin
		cycles++;
		if (intPulse === 1'b1) pulseCnt++;
		if (cycles == 40000) begin
			errorCnt++;
			endOfTest();
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			errorCnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic chk_reg(input string what, input logic [7:0] ptr, input logic [7:0] exp);
		i_host.read_regs(ptr, 1);
		check(what, i_host.rd[0], exp);
	endtask

	// longer than the three-cycle condition latency
	task automatic settle();
		repeat (10) @(negedge clk);
	endtask

	task automatic set_a(input logic [7:0] v);
		@(negedge clk);
		{cond.inCurReg, cond.inVoltReg, cond.wdExpired, cond.weakAdapter, cond.powerGood,
			cond.adBPresent, cond.adAPresent, cond.busPresent} = v;
		settle();
	endtask

	task automatic set_b(input logic [2:0] cs, input logic [1:0] ico, input logic [3:0] bt,
			input logic [2:0] lv);
		@(negedge clk);
		cond.chargeState = cs;
		cond.icoState = ico;
		cond.busType = bt;
		{cond.dieThermReg, cond.battPresent, cond.portDetDone} = lv;
		settle();
	endtask

	task automatic t_reset();
		logic a;
		i_host.read_regs(OFS_TEMP, 5);
		for (int k = 0; k < 5; k++) check("reset value", i_host.rd[k], REG_RESET);
		chk_reg("unmapped offset", 8'h30, 8'h00);
		i_host.probe(DEV_ADDR_DEF ^ 7'h01, a);
		check("foreign address ack", {7'h0, a}, 8'h00);
		i_host.probe(DEV_ADDR_DEF, a);
		check("own address ack", {7'h0, a}, 8'h01);
		i_host.write_reg(OFS_FLAGA, 8'hff);
		chk_reg("flag a after write", OFS_FLAGA, 8'h00);
		$display("test reset done");
	endtask

	// walk all five thermistor ranges with changing fault patterns
	task automatic t_status();
		logic [7:0] fa;
		logic [4:0] fb;
		logic [7:0] ts;
		for (int k = 0; k < 5; k++) begin
			fa = k[0] ? 8'ha5 : 8'h5a;
			fb = k[0] ? 5'h15 : 5'h0a;
			@(negedge clk);
			{cond.belowT1, cond.belowT2, cond.belowT3, cond.belowT5} = {k < 1, k < 2, k < 3, k < 4};
			cond.otgBattLow = k[0];
			{cond.dischgReg, cond.busOv, cond.battOv, cond.busOc, cond.battOc, cond.convOc,
				cond.adBOv, cond.adAOv} = fa;
			{cond.sysShort, cond.sysOv, cond.otgOv, cond.otgUv, cond.thermShut} = fb;
			settle();
			i_host.read_regs(OFS_TEMP, 3);
			ts = {3'h0, k[0], k == 0, k == 1, k == 3, k == 4};
			check("temp status", i_host.rd[0], ts);
			check("fault a", i_host.rd[1], fa);
			check("fault b", i_host.rd[2], {fb[4:1], 1'b0, fb[0], 2'b00});
		end
		$display("test status done");
	endtask

	task automatic t_flag_a();
		int p0;
		p0 = pulseCnt;
		set_a(8'hff);
		check("pulse a", 8'(pulseCnt > p0), 8'h01);
		chk_reg("flag a rise", OFS_FLAGA, 8'hff);
		chk_reg("flag a cleared", OFS_FLAGA, 8'h00);
		set_a(8'h00);
		chk_reg("flag a fall", OFS_FLAGA, 8'h0f);
		set_a(8'h80);
		set_a(8'h00);
		chk_reg("flag a held", OFS_FLAGA, 8'h80);
		$display("test flag a done");
	endtask

	task automatic t_flag_b();
		int p0;
		p0 = pulseCnt;
		set_b(3'h5, 2'h2, 4'hb, 3'h7);
		check("pulse b", 8'(pulseCnt > p0), 8'h01);
		chk_reg("flag b set", OFS_FLAGB, 8'hd7);
		set_b(3'h5, 2'h2, 4'hb, 3'h3);
		chk_reg("flag b therm fall", OFS_FLAGB, 8'h00);
		set_b(3'h5, 2'h2, 4'h3, 3'h3);
		chk_reg("flag b bus type", OFS_FLAGB, 8'h10);
		set_b(3'h0, 2'h0, 4'h0, 3'h0);
		chk_reg("flag b all fall", OFS_FLAGB, 8'hd3);
		$display("test flag b done");
	endtask

	// masks gate only the pulse, never the flag
	task automatic t_mask();
		int p0;
		@(negedge clk);
		irqMask = 16'h8000;
		p0 = pulseCnt;
		set_a(8'h80);
		check("masked pulse a", 8'(pulseCnt - p0), 8'h00);
		irqMask = 16'hfffe;
		p0 = pulseCnt;
		set_b(3'h0, 2'h0, 4'h0, 3'h1);
		check("single pulse", 8'(pulseCnt - p0), 8'h01);
		irqMask = 16'h0001;
		p0 = pulseCnt;
		set_b(3'h0, 2'h0, 4'h0, 3'h0);
		check("masked pulse b", 8'(pulseCnt - p0), 8'h00);
		i_host.read_regs(OFS_FLAGA, 2);
		check("masked flag a", i_host.rd[0], 8'h80);
		check("masked flag b", i_host.rd[1], 8'h01);
		check("missing acks", 8'(i_host.ackMiss), 8'h00);
		$display("test mask done");
	endtask

	// a low enable freezes the bank, so the event only lands after release
	task automatic t_freeze();
		int p0;
		@(negedge clk);
		ce = 1'b0;
		p0 = pulseCnt;
		set_a(8'h08);
		check("frozen pulse", 8'(pulseCnt - p0), 8'h00);
		ce = 1'b1;
		settle();
		check("thawed pulse", 8'(pulseCnt - p0), 8'h01);
		chk_reg("thawed flag a", OFS_FLAGA, 8'h08);
		$display("test freeze done");
	endtask

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", samplesChecked, errorCnt);
		if (errorCnt == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// mid-range temperature so the status register starts at zero
	initial begin
		reset_n = 1'b0;
		ce = 1'b1;
		irqMask = 16'h0000;
		cond = '0;
		cond.belowT3 = 1'b1;
		cond.belowT5 = 1'b1;
		repeat (10) @(negedge clk);
		reset_n = 1'b1;
		repeat (10) @(negedge clk);
		t_reset();
		t_status();
		t_flag_a();
		t_flag_b();
		t_mask();
		t_freeze();
		endOfTest();
	end
endmodule

`default_nettype wire
